//--- hdl/fpp_pkg.sv
// shared constants, types and helpers for the parallel configuration load link
package fpp_pkg;
    localparam int CLK_MHZ          = 125;
    localparam int T_CF2CD_NS       = 600;
    localparam int T_CF2ST0_NS      = 600;
    localparam int T_CFG_US         = 2;
    localparam int T_STATUS_MIN_US  = 268;
    localparam int T_STATUS_MAX_US  = 1506;
    localparam int T_CF2CK_US       = 1506;
    localparam int T_ST2CK_US       = 2;
    localparam int T_CD2UM_MIN_US   = 175;
    localparam int T_CD2UM_MAX_US   = 437;
    localparam int T_CCLK_MAX_NS    = 8;
    localparam int CD2CU_PERIODS    = 4;
    localparam int USER_INIT_PER    = 8576;
    // longest time rounds down, least time rounds up
    localparam int CF2CD_CYC        = T_CF2CD_NS * CLK_MHZ / 1000;
    localparam int CF2ST0_CYC       = T_CF2ST0_NS * CLK_MHZ / 1000;
    localparam int CFG_CYC          = T_CFG_US * CLK_MHZ;
    localparam int STATUS_MIN_CYC   = T_STATUS_MIN_US * CLK_MHZ;
    localparam int STATUS_MAX_CYC   = T_STATUS_MAX_US * CLK_MHZ;
    localparam int CF2CK_CYC        = T_CF2CK_US * CLK_MHZ;
    localparam int ST2CK_CYC        = T_ST2CK_US * CLK_MHZ;
    localparam int CD2UM_MIN_CYC    = T_CD2UM_MIN_US * CLK_MHZ;
    localparam int CD2UM_MAX_CYC    = T_CD2UM_MAX_US * CLK_MHZ;
    localparam int CD2CU_CYC        = (CD2CU_PERIODS * T_CCLK_MAX_NS * CLK_MHZ + 999) / 1000;
    localparam int CCLK_HALF        = 5;
    localparam int CCLK_DIV         = 2 * CCLK_HALF;
    localparam int CNT_W            = 18;
    localparam int DATA_W           = 32;

    typedef enum logic [1:0] {
        WIDTH_8  = 2'b00,
        WIDTH_16 = 2'b01,
        WIDTH_32 = 2'b10
    } width_e;

    function automatic logic [2:0] ratio_of(width_e w, logic decomp, logic secure);
        ratio_of = 3'h1;
        if (w == WIDTH_8 && decomp) ratio_of = 3'h2;
        if (w == WIDTH_16 && decomp) ratio_of = 3'h4;
        else if (w == WIDTH_16 && secure) ratio_of = 3'h2;
    endfunction
endpackage

//--- hdl/fpp_link_if.sv
// pins between configuration host and configured device
`timescale 1ns/1ps
interface fpp_link_if;
    logic              config_request_n;
    logic              status_dev_o;
    logic              status_dev_oe;
    logic              status_host_o;
    logic              status_host_oe;
    logic              config_status_n;
    logic              load_complete;
    logic              config_clock;
    logic              user_init_clock;
    logic [31:0]       data;

    // open-drain with pull-up: low while any enabled driver pulls low
    assign config_status_n = !((status_dev_oe && !status_dev_o) ||
                               (status_host_oe && !status_host_o));

    modport device (input config_request_n, config_status_n, config_clock,
                    user_init_clock, data,
                    output status_dev_o, status_dev_oe, load_complete);
    modport host (output config_request_n, status_host_o, status_host_oe,
                  config_clock, user_init_clock, data,
                  input config_status_n, load_complete);
endinterface

//--- hdl/fpp_device.sv
// configured-device end: clear, handshake, word capture, initialization
`timescale 1ns/1ps
module fpp_device
    import fpp_pkg::*;
#(
    parameter int STATUS_MIN = STATUS_MIN_CYC,
    parameter int INIT_CYC   = CD2UM_MIN_CYC,
    parameter int USER_PER   = USER_INIT_PER
) (
    input  wire logic          clk,
    input  wire logic          srst,
    fpp_link_if.device         link,
    input  wire width_e        width_sel,
    input  wire logic          decompress,
    input  wire logic          security,
    input  wire logic          init_from_user_clock,
    input  wire logic [31:0]   image_words,
    output logic [31:0]        word_data,
    output logic               word_valid,
    output logic               user_mode
);
    typedef enum logic [2:0] {
        D_CLEAR = 3'h0,
        D_WAIT  = 3'h1,
        D_LOAD  = 3'h2,
        D_INIT  = 3'h3,
        D_USER  = 3'h4
    } dev_state_e;

    typedef struct packed {
        dev_state_e        st;
        logic              req_s1, req_s2;
        logic              stat_s1, stat_s2;
        logic              cclk_s1, cclk_s2, cclk_s3;
        logic              uclk_s1, uclk_s2, uclk_s3;
        logic [31:0]       dat_s1, dat_s2;
        logic [CNT_W-1:0]  cnt;
        logic [2:0]        ratio;
        logic [1:0]        grp;
        logic [31:0]       words;
        logic              status_low;
        logic              done;
        logic              umode;
        logic [31:0]       word;
        logic              wvalid;
    } dev_s;

    dev_s r_r, r_nxt;

    always_comb begin
        r_nxt = r_r;
        r_nxt.wvalid = 1'b0;
        r_nxt.req_s1 = link.config_request_n;
        r_nxt.req_s2 = r_r.req_s1;
        r_nxt.stat_s1 = link.config_status_n;
        r_nxt.stat_s2 = r_r.stat_s1;
        r_nxt.cclk_s1 = link.config_clock;
        r_nxt.cclk_s2 = r_r.cclk_s1;
        r_nxt.cclk_s3 = r_r.cclk_s2;
        r_nxt.uclk_s1 = link.user_init_clock;
        r_nxt.uclk_s2 = r_r.uclk_s1;
        r_nxt.uclk_s3 = r_r.uclk_s2;
        r_nxt.dat_s1 = link.data;
        r_nxt.dat_s2 = r_r.dat_s1;
        // three cycles after the pin, far inside the 600 ns limit
        if (!r_r.req_s2 && r_r.st != D_CLEAR) begin
            r_nxt.st = D_CLEAR;
            r_nxt.cnt = '0;
            r_nxt.done = 1'b0;
            r_nxt.status_low = 1'b1;
            r_nxt.umode = 1'b0;
        end else begin
            case (r_r.st)
                D_CLEAR: begin
                    r_nxt.status_low = 1'b1;
                    if (r_r.cnt < CNT_W'(STATUS_MIN - 1))
                        r_nxt.cnt = r_r.cnt + 1'b1;
                    // a long request pulse stretches the low time
                    else if (r_r.req_s2) begin
                        r_nxt.status_low = 1'b0;
                        r_nxt.st = D_WAIT;
                        r_nxt.ratio = ratio_of(width_sel, decompress, security);
                        r_nxt.grp = '0;
                        r_nxt.words = '0;
                    end
                end
                D_WAIT: begin
                    if (r_r.stat_s2)
                        r_nxt.st = D_LOAD;
                end
                D_LOAD: begin
                    if (r_r.cclk_s2 && !r_r.cclk_s3) begin
                        // only the first edge of each group carries a new word
                        if (r_r.grp == 2'h0) begin
                            r_nxt.word = r_r.dat_s2;
                            r_nxt.wvalid = 1'b1;
                            r_nxt.words = r_r.words + 1'b1;
                        end
                        r_nxt.grp = (r_r.grp == 2'(r_r.ratio - 3'h1)) ? 2'h0 : r_r.grp + 1'b1;
                        // count already holds the word taken at this group's first edge
                        if (r_r.grp == 2'(r_r.ratio - 3'h1) &&
                            r_nxt.words == image_words + 32'h0000_0001) begin
                            r_nxt.done = 1'b1;
                            r_nxt.st = D_INIT;
                            r_nxt.cnt = '0;
                        end
                    end
                end
                D_INIT: begin
                    if (init_from_user_clock) begin
                        if (r_r.uclk_s2 && !r_r.uclk_s3)
                            r_nxt.cnt = r_r.cnt + 1'b1;
                        if (r_r.cnt == CNT_W'(USER_PER))
                            r_nxt.st = D_USER;
                    end else begin
                        r_nxt.cnt = r_r.cnt + 1'b1;
                        if (r_r.cnt == CNT_W'(INIT_CYC - 1))
                            r_nxt.st = D_USER;
                    end
                end
                D_USER: r_nxt.umode = 1'b1;
                default: r_nxt.st = D_CLEAR;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r_r <= '0;
            r_r.st <= D_CLEAR;
            r_r.status_low <= 1'b1;
            r_r.req_s1 <= 1'b1;
            r_r.req_s2 <= 1'b1;
            r_r.ratio <= 3'h1;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign link.status_dev_o  = 1'b0;
    assign link.status_dev_oe = r_r.status_low;
    assign link.load_complete = r_r.done;
    assign word_data  = r_r.word;
    assign word_valid = r_r.wvalid;
    assign user_mode  = r_r.umode;
endmodule

//--- hdl/fpp_host.sv
// configuration host end: request pulse, handshake wait, word stream, init clock
`timescale 1ns/1ps
module fpp_host
    import fpp_pkg::*;
#(
    parameter int CF2CK = CF2CK_CYC
) (
    input  wire logic          clk,
    input  wire logic          srst,
    fpp_link_if.host           link,
    input  wire logic          start,
    input  wire width_e        width_sel,
    input  wire logic          decompress,
    input  wire logic          security,
    input  wire logic          use_user_clock,
    input  wire logic          watch_status,
    input  wire logic [31:0]   word_count,
    input  wire logic [31:0]   in_data,
    input  wire logic          in_valid,
    output logic               in_ready,
    output logic               busy,
    output logic               done,
    output logic               error
);
    typedef enum logic [2:0] {
        H_IDLE  = 3'h0,
        H_PULSE = 3'h1,
        H_WAIT  = 3'h2,
        H_SEND  = 3'h3,
        H_DONE  = 3'h4,
        H_UDLY  = 3'h5,
        H_FIN   = 3'h6
    } host_state_e;

    typedef struct packed {
        host_state_e       st;
        logic              req_n;
        logic [CNT_W-1:0]  cnt;
        logic [3:0]        div;
        logic              cclk;
        logic [3:0]        udiv;
        logic              urun;
        logic              uclk;
        logic [2:0]        ratio;
        logic [1:0]        grp;
        logic [31:0]       sent;
        logic [31:0]       data;
        logic              stat_s1, stat_s2;
        logic              lc_s1, lc_s2;
        logic [1:0][31:0]  mem;
        logic              wp, rp;
        logic [1:0]        fill;
        logic              err;
        logic              fin;
    } host_s;

    host_s r_r, r_nxt;

    logic push;
    logic pop;
    logic last_grp;

    // two entries let the source run two words ahead of the link
    assign in_ready = (r_r.fill != 2'h2);
    assign push     = in_valid && in_ready;
    assign last_grp = (r_r.grp == 2'(r_r.ratio - 3'h1));

    always_comb begin
        r_nxt = r_r;
        pop = 1'b0;
        r_nxt.stat_s1 = link.config_status_n;
        r_nxt.stat_s2 = r_r.stat_s1;
        r_nxt.lc_s1 = link.load_complete;
        r_nxt.lc_s2 = r_r.lc_s1;
        case (r_r.st)
            // a start seen in the finished state begins the next load at once
            H_IDLE, H_FIN: begin
                if (r_r.st == H_FIN)
                    r_nxt.fin = 1'b1;
                if (start) begin
                    r_nxt.st = H_PULSE;
                    r_nxt.urun = 1'b0;
                    r_nxt.uclk = 1'b0;
                    r_nxt.req_n = 1'b0;
                    r_nxt.cnt = '0;
                    r_nxt.ratio = ratio_of(width_sel, decompress, security);
                    r_nxt.sent = '0;
                    r_nxt.grp = '0;
                    r_nxt.div = '0;
                    r_nxt.err = 1'b0;
                    r_nxt.fin = 1'b0;
                end
            end
            H_PULSE: begin
                r_nxt.cnt = r_r.cnt + 1'b1;
                if (r_r.cnt == CNT_W'(CFG_CYC - 1)) begin
                    r_nxt.req_n = 1'b1;
                    r_nxt.cnt = '0;
                    r_nxt.st = H_WAIT;
                end
            end
            H_WAIT: begin
                // with watch_status set, count restarts whenever the handshake is still low
                if (watch_status) begin
                    r_nxt.cnt = r_r.stat_s2 ? r_r.cnt + 1'b1 : '0;
                    if (r_r.stat_s2 && r_r.cnt == CNT_W'(ST2CK_CYC - 1))
                        r_nxt.st = H_SEND;
                end else begin
                    r_nxt.cnt = r_r.cnt + 1'b1;
                    if (r_r.cnt == CNT_W'(CF2CK - 1))
                        r_nxt.st = H_SEND;
                end
            end
            H_SEND: begin
                if (watch_status && !r_r.stat_s2) begin
                    r_nxt.err = 1'b1;
                    r_nxt.cclk = 1'b0;
                    r_nxt.st = H_IDLE;
                end else if (r_r.div == 4'h0 && r_r.grp == 2'h0) begin
                    // clock parks low while the buffer is empty
                    if (r_r.fill != 2'h0) begin
                        pop = 1'b1;
                        r_nxt.data = r_r.mem[r_r.rp];
                        r_nxt.rp = ~r_r.rp;
                        r_nxt.sent = r_r.sent + 1'b1;
                        r_nxt.div = 4'h1;
                    end
                end else begin
                    r_nxt.div = (r_r.div == 4'(CCLK_DIV - 1)) ? 4'h0 : r_r.div + 1'b1;
                    // 80 ns period keeps well under either width limit
                    if (r_r.div == 4'(CCLK_HALF - 1))
                        r_nxt.cclk = 1'b1;
                    if (r_r.div == 4'(CCLK_DIV - 1)) begin
                        r_nxt.cclk = 1'b0;
                        // data stays put through the remaining edges of the group
                        r_nxt.grp = last_grp ? 2'h0 : r_r.grp + 1'b1;
                        if (last_grp && r_r.sent == word_count)
                            r_nxt.st = H_DONE;
                    end
                end
            end
            H_DONE: begin
                r_nxt.cnt = '0;
                if (r_r.lc_s2)
                    r_nxt.st = use_user_clock ? H_UDLY : H_FIN;
            end
            H_UDLY: begin
                r_nxt.cnt = r_r.cnt + 1'b1;
                if (r_r.cnt == CNT_W'(CD2CU_CYC - 1)) begin
                    r_nxt.urun = 1'b1;
                    r_nxt.udiv = '0;
                    r_nxt.st = H_FIN;
                end
            end
            default: r_nxt.st = H_IDLE;
        endcase
        // user clock runs free until the next load, device counts what it needs
        if (r_r.urun && r_r.st == H_FIN && !start) begin
            r_nxt.udiv = (r_r.udiv == 4'(CCLK_HALF - 1)) ? 4'h0 : r_r.udiv + 1'b1;
            if (r_r.udiv == 4'(CCLK_HALF - 1))
                r_nxt.uclk = ~r_r.uclk;
        end
        if (push) begin
            r_nxt.mem[r_r.wp] = in_data;
            r_nxt.wp = ~r_r.wp;
        end
        r_nxt.fill = r_r.fill + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r_r <= '0;
            r_r.st <= H_IDLE;
            r_r.req_n <= 1'b1;
            r_r.ratio <= 3'h1;
            r_r.stat_s1 <= 1'b1;
            r_r.stat_s2 <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign link.config_request_n = r_r.req_n;
    assign link.status_host_o    = 1'b0;
    assign link.status_host_oe   = 1'b0;
    assign link.config_clock     = r_r.cclk;
    assign link.user_init_clock  = r_r.uclk;
    assign link.data             = r_r.data;
    assign busy  = (r_r.st != H_IDLE) && (r_r.st != H_FIN);
    assign done  = r_r.fin;
    assign error = r_r.err;
endmodule

//--- sim/fpp_link_sva.sv
// checker for the parallel configuration load link pins
`timescale 1ns/1ps
module fpp_link_sva
    import fpp_pkg::*;
#(
    parameter int CF2CK  = CF2CK_CYC,
    parameter int ST_MAX = STATUS_MAX_CYC,
    parameter int ST_MIN = STATUS_MIN_CYC
) (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        config_request_n,
    input wire logic        config_status_n,
    input wire logic        load_complete,
    input wire logic        config_clock,
    input wire logic        user_init_clock,
    input wire logic [31:0] data
);
    localparam int CF2CD_MAX = CF2CD_CYC;
    localparam int CF2ST_MAX = CF2ST0_CYC;
    typedef struct packed {
        int req_hi;
        int req_lo;
        int st_hi;
        int st_lo;
        int st_wait;
        int cd_hi;
    } cnt_s;
    cnt_s c_r;
    cnt_s c_nxt;

    // run lengths of each level; short sims keep them far from overflow
    always_comb begin
        c_nxt         = c_r;
        c_nxt.req_hi  = config_request_n ? c_r.req_hi + 1 : 0;
        c_nxt.req_lo  = config_request_n ? 0 : c_r.req_lo + 1;
        c_nxt.st_hi   = config_status_n ? c_r.st_hi + 1 : 0;
        c_nxt.st_lo   = config_status_n ? 0 : c_r.st_lo + 1;
        c_nxt.st_wait = (!config_status_n && config_request_n) ? c_r.st_wait + 1 : 0;
        c_nxt.cd_hi   = load_complete ? c_r.cd_hi + 1 : 0;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            c_r <= '0;
        end else begin
            c_r <= c_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    clear_done_a: assert property ($fell(config_request_n) |-> ##[1:CF2CD_MAX] !load_complete)
        else $error("load complete not cleared after request");
    status_low_a: assert property ($fell(config_request_n) |-> ##[1:CF2ST_MAX] !config_status_n)
        else $error("status not pulled low after request");
    req_pulse_a: assert property ($rose(config_request_n) |-> c_r.req_lo >= CFG_CYC)
        else $error("request pulse too short");
    status_min_a: assert property ($rose(config_status_n) |-> c_r.st_lo >= ST_MIN - 2)
        else $error("status low pulse too short");
    status_max_a: assert property (c_r.st_wait <= ST_MAX)
        else $error("status held low too long after request high");
    first_edge_a: assert property ($rose(config_clock) |-> c_r.st_hi >= ST2CK_CYC || c_r.req_hi >= CF2CK)
        else $error("config clock edge too early");
    clock_high_a: assert property ($rose(config_clock) |-> config_clock [*5] ##1 !config_clock)
        else $error("config clock high time wrong");
    data_setup_a: assert property ($changed(data) |-> !config_clock [*4])
        else $error("data changed too close to a clock edge");
    user_clock_a: assert property ($rose(user_init_clock) |-> load_complete && c_r.cd_hi >= CD2CU_CYC)
        else $error("user init clock started too early");
    data_hold_a: assert property ($rose(config_clock) |-> $stable(data) [*5])
        else $error("data changed while config clock high");

    cover property ($rose(load_complete));
    cover property ($rose(user_init_clock));
    cover property ($rose(config_status_n) ##[1:300] $rose(config_clock));
endmodule

//--- sim/fpp_config_load_ratio_gt1_tb.sv
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
module fpp_config_load_ratio_gt1_tb
    import fpp_pkg::*;
;
    localparam int STMIN = 40;
    localparam int INITC = 30;
    localparam int UPER  = 20;
    localparam int CFCK  = 60;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        start = 1'b0;
    width_e      width_sel = WIDTH_8;
    logic        decompress = 1'b0;
    logic        security = 1'b0;
    logic        use_user_clock = 1'b0;
    logic        watch_status = 1'b1;
    logic [31:0] word_count = 32'h0000_0001;
    logic [31:0] in_data = 32'h0000_0000;
    logic        in_valid = 1'b0;
    logic        in_ready;
    logic        busy;
    logic        done;
    logic        error;
    logic [31:0] word_data;
    logic        word_valid;
    logic        user_mode;
    logic [31:0] mask = 32'hFFFF_FFFF;
    logic [31:0] exp_q[$];
    logic        lc_d = 1'b0;
    logic        um_d = 1'b0;
    logic        ck_d = 1'b0;
    int          seed = 82;
    int          fail_count = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          lc_cyc = 0;
    int          um_cyc = 0;
    int          rises = 0;

    always #4 clk = ~clk;

    fpp_link_if link ();
    fpp_device #(.STATUS_MIN(STMIN), .INIT_CYC(INITC), .USER_PER(UPER)) i_fpp_device (
        .clk(clk), .srst(srst), .link(link), .width_sel(width_sel), .decompress(decompress),
        .security(security), .init_from_user_clock(use_user_clock),
        .image_words(word_count - 32'h0000_0001), .word_data(word_data),
        .word_valid(word_valid), .user_mode(user_mode));
    fpp_host #(.CF2CK(CFCK)) i_fpp_host (
        .clk(clk), .srst(srst), .link(link), .start(start), .width_sel(width_sel),
        .decompress(decompress), .security(security), .use_user_clock(use_user_clock),
        .watch_status(watch_status), .word_count(word_count), .in_data(in_data),
        .in_valid(in_valid), .in_ready(in_ready), .busy(busy), .done(done), .error(error));
    fpp_link_sva #(.CF2CK(CFCK), .ST_MAX(STMIN + 8), .ST_MIN(STMIN)) i_fpp_link_sva (
        .clk(clk), .srst(srst), .config_request_n(link.config_request_n),
        .config_status_n(link.config_status_n), .load_complete(link.load_complete),
        .config_clock(link.config_clock), .user_init_clock(link.user_init_clock),
        .data(link.data));

    task automatic print_verdict();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic check_span(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // every wait is bounded; running out ends the run as a failure
    task automatic wait_hi(ref logic s, input int lim);
        int k;
        k = 0;
        while (s !== 1'b1) begin
            @(negedge clk);
            k++;
            if (k > lim) begin
                check_bit(1'b0, 1'b1);
                print_verdict();
            end
        end
    endtask

    // sampled mid-cycle, where every registered output has settled
    always @(negedge clk) begin
        cyc++;
        if (link.load_complete === 1'b1 && lc_d !== 1'b1) lc_cyc = cyc;
        if (user_mode === 1'b1 && um_d !== 1'b1) um_cyc = cyc;
        if (link.config_clock === 1'b1 && ck_d !== 1'b1) rises++;
        if (word_valid === 1'b1) begin
            if (exp_q.size() == 0) check_bit(1'b0, 1'b1);
            else check_word(word_data & mask, exp_q.pop_front());
        end
        lc_d = link.load_complete;
        um_d = user_mode;
        ck_d = link.config_clock;
    end

    task automatic run_cfg(input width_e w, input logic dec, input logic sec,
                           input logic uck, input logic wst, input int nr);
        int n;
        int gap;
        int i;
        @(negedge clk);
        width_sel = w;
        decompress = dec;
        security = sec;
        use_user_clock = uck;
        watch_status = wst;
        n = 3 + ($unsigned($random(seed)) % 4);
        word_count = n;
        mask = (w == WIDTH_8) ? 32'h0000_00FF : (w == WIDTH_16) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
        lc_cyc = 0;
        um_cyc = 0;
        rises = 0;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        // words queue up during the handshake, so the buffer fills and refuses
        for (i = 0; i < n; i++) begin
            // valid drops for whole cycles only, never as a zero-width glitch
            gap = $unsigned($random(seed)) % 3;
            if (gap != 0) begin
                in_valid = 1'b0;
                repeat (gap) @(negedge clk);
            end
            in_data = $random(seed);
            in_valid = 1'b1;
            wait_hi(in_ready, 5000);
            exp_q.push_back(in_data & mask);
            @(negedge clk);
        end
        in_valid = 1'b0;
        wait_hi(done, 20000);
        check_bit(error, 1'b0);
        check_bit(busy, 1'b0);
        check_bit(link.load_complete, 1'b1);
        check_span(rises, n * nr, n * nr);
        check_span(exp_q.size(), 0, 0);
        wait_hi(user_mode, 2000);
        // one more cycle so the watcher has noted the user-mode edge
        @(negedge clk);
        if (uck) check_span(um_cyc - lc_cyc, UPER * CCLK_DIV, UPER * CCLK_DIV + 40);
        else check_span(um_cyc - lc_cyc, INITC, INITC * T_CD2UM_MAX_US / T_CD2UM_MIN_US);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        run_cfg(WIDTH_8, 1'b1, 1'b0, 1'b0, 1'b1, 2);
        run_cfg(WIDTH_16, 1'b1, 1'b1, 1'b1, 1'b1, 4);
        run_cfg(WIDTH_16, 1'b0, 1'b1, 1'b0, 1'b0, 2);
        run_cfg(WIDTH_32, 1'b0, 1'b0, 1'b1, 1'b1, 1);
        run_cfg(WIDTH_8, 1'b0, 1'b1, 1'b0, 1'b1, 1);
        print_verdict();
    end
endmodule
